// file: verilog/ifsb_regs.svh
// Offsets, field positions, masks and reset values of the flag status bank
`ifndef IFSB_REGS_SVH
`define IFSB_REGS_SVH

// Byte offsets of the two flag words on the bus
`define IFSB_OFS_FLAGS_ONE     32'h0000_0000
`define IFSB_OFS_FLAGS_TWO     32'h0000_0004
`define IFSB_OFS_MASK          32'h0000_00FC

// Reset value and implemented-bit masks
`define IFSB_FLAGS_RESET       16'h0000
`define IFSB_IMPL_ONE          16'hFFFB
`define IFSB_IMPL_TWO          16'hDFFF
`define IFSB_RSVD_ONE          2
`define IFSB_RSVD_TWO          13

// Field positions, first flag word
`define IFSB_UART_B_TX_PENDING      15
`define IFSB_UART_B_RX_PENDING      14
`define IFSB_EXT_IRQ_B_PENDING      13
`define IFSB_TIMER_FIVE_PENDING     12
`define IFSB_TIMER_FOUR_PENDING     11
`define IFSB_COMPARE_OUT_FOUR_PEND  10
`define IFSB_COMPARE_OUT_THREE_PEND 9
`define IFSB_DMA_CHAN_TWO_DONE      8
`define IFSB_CAPTURE_EIGHT_PENDING  7
`define IFSB_CAPTURE_SEVEN_PENDING  6
`define IFSB_ADC_B_DONE_PENDING     5
`define IFSB_EXT_IRQ_A_PENDING      4
`define IFSB_PIN_CHANGE_PENDING     3
`define IFSB_I2C_A_MASTER_PENDING   1
`define IFSB_I2C_A_SLAVE_PENDING    0

// Field positions, second flag word
`define IFSB_TIMER_SIX_PENDING      15
`define IFSB_DMA_CHAN_FOUR_DONE     14
`define IFSB_COMPARE_OUT_EIGHT_PEND 12
`define IFSB_COMPARE_OUT_SEVEN_PEND 11
`define IFSB_COMPARE_OUT_SIX_PEND   10
`define IFSB_COMPARE_OUT_FIVE_PEND  9
`define IFSB_CAPTURE_SIX_PENDING    8
`define IFSB_CAPTURE_FIVE_PENDING   7
`define IFSB_CAPTURE_FOUR_PENDING   6
`define IFSB_CAPTURE_THREE_PENDING  5
`define IFSB_DMA_CHAN_THREE_DONE    4
`define IFSB_CAN_A_EVENT_PENDING    3
`define IFSB_CAN_A_RX_READY_PENDING 2
`define IFSB_SPI_B_EVENT_PENDING    1
`define IFSB_SPI_B_ERROR_PENDING    0

`endif

// file: verilog/ifsb_pkg.sv
// Types shared by the flag status bank
package ifsb_pkg;

    // Bus slave phase, Gray coded along idle -> data -> idle
    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_WRITE = 2'b01,
        PH_READ  = 2'b10
    } ifsb_phase_t;

    typedef logic [15:0] ifsb_word_t;

endpackage : ifsb_pkg

// file: verilog/ifsb_flag_word.sv
// One 16-bit sticky flag word with software read/write access
`timescale 1ns/100ps
`include "ifsb_regs.svh"

module ifsb_flag_word #(
    parameter logic [15:0] IMPL_MASK = 16'hFFFF
) (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic [15:0] setEvt,
    input  wire logic        wrEn,
    input  wire logic [15:0] wrData,
    output logic      [15:0] flags_q
);

    logic [15:0] base;
    logic [15:0] flags_d;

    // Written value replaces the word; a same-cycle event still wins
    assign base    = wrEn ? wrData : flags_q;
    assign flags_d = (base | setEvt) & IMPL_MASK;

    // Flags clear only on reset or by a software write of zero
    always_ff @(posedge core_clk)
    begin
        if (rst)
            flags_q <= `IFSB_FLAGS_RESET;
        else
            flags_q <= flags_d;
    end

endmodule : ifsb_flag_word

// file: verilog/ifsb_ahb_port.sv
// AHB-Lite slave phase tracker: one wait state, in which the data phase acts
`timescale 1ns/100ps

module ifsb_ahb_port (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic        hready,
    output logic             hreadyout_q,
    output logic      [31:0] addr_q,
    output logic             wrStb,
    output logic             rdStb
);

    ifsb_pkg::ifsb_phase_t phase_q;
    ifsb_pkg::ifsb_phase_t phase_d;
    logic                  accept;

    // Only NONSEQ/SEQ with the bus ready start a transfer
    assign accept = hsel & htrans[1] & hready;
    assign wrStb  = (phase_q == ifsb_pkg::PH_WRITE);
    assign rdStb  = (phase_q == ifsb_pkg::PH_READ);

    // Next phase; data phase always lasts exactly one stalled cycle
    always_comb
    begin
        case (phase_q)
            ifsb_pkg::PH_IDLE:
                phase_d = accept ? (hwrite ? ifsb_pkg::PH_WRITE : ifsb_pkg::PH_READ)
                                 : ifsb_pkg::PH_IDLE;
            ifsb_pkg::PH_WRITE: phase_d = ifsb_pkg::PH_IDLE;
            ifsb_pkg::PH_READ:  phase_d = ifsb_pkg::PH_IDLE;
            default:            phase_d = ifsb_pkg::PH_IDLE;
        endcase
    end

    // Wait state lets read data come from a flop and see fresh flags
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            phase_q     <= ifsb_pkg::PH_IDLE;
            hreadyout_q <= 1'b1;
            addr_q      <= 32'h0000_0000;
        end
        else
        begin
            phase_q     <= phase_d;
            hreadyout_q <= (phase_d == ifsb_pkg::PH_IDLE);
            if (accept && phase_q == ifsb_pkg::PH_IDLE)
                addr_q <= haddr;
        end
    end

endmodule : ifsb_ahb_port

// file: verilog/ifsb_flag_bank.sv
// Interrupt flag status bank: two sticky flag words behind an AHB-Lite slave
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`include "ifsb_regs.svh"

module ifsb_flag_bank (
    input  wire logic        core_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    input  wire logic        uartBTxEvt,
    input  wire logic        uartBRxEvt,
    input  wire logic        extIrqBEvt,
    input  wire logic        timerFiveEvt,
    input  wire logic        timerFourEvt,
    input  wire logic        compareOutFourEvt,
    input  wire logic        compareOutThreeEvt,
    input  wire logic        dmaChanTwoEvt,
    input  wire logic        captureEightEvt,
    input  wire logic        captureSevenEvt,
    input  wire logic        adcBDoneEvt,
    input  wire logic        extIrqAEvt,
    input  wire logic        pinChangeEvt,
    input  wire logic        i2cAMasterEvt,
    input  wire logic        i2cASlaveEvt,
    input  wire logic        timerSixEvt,
    input  wire logic        dmaChanFourEvt,
    input  wire logic        compareOutEightEvt,
    input  wire logic        compareOutSevenEvt,
    input  wire logic        compareOutSixEvt,
    input  wire logic        compareOutFiveEvt,
    input  wire logic        captureSixEvt,
    input  wire logic        captureFiveEvt,
    input  wire logic        captureFourEvt,
    input  wire logic        captureThreeEvt,
    input  wire logic        dmaChanThreeEvt,
    input  wire logic        canAEventEvt,
    input  wire logic        canARxReadyEvt,
    input  wire logic        spiBEventEvt,
    input  wire logic        spiBErrorEvt,
    output logic      [15:0] flagsOne,
    output logic      [15:0] flagsTwo
);

    // Word decode shared by the write and read paths
    function automatic logic hitReg(input logic [31:0] addr, input logic [31:0] ofs);
        hitReg = ((addr & `IFSB_OFS_MASK) == ofs) && (addr[31:8] == 24'h00_0000);
    endfunction : hitReg

    ifsb_pkg::ifsb_word_t setOne;
    ifsb_pkg::ifsb_word_t setTwo;
    logic [31:0]          addr_q;
    logic [31:0]          hrdata_q;
    logic                 hresp_q;
    logic                 hreadyout_q;
    logic                 wrStb;
    logic                 rdStb;
    logic                 hitOne;
    logic                 hitTwo;
    logic                 wrOne;
    logic                 wrTwo;
    logic [31:0]          rdMux;

    // Event wiring, first word; reserved bit has no source
    assign setOne[`IFSB_UART_B_TX_PENDING]      = uartBTxEvt;
    assign setOne[`IFSB_UART_B_RX_PENDING]      = uartBRxEvt;
    assign setOne[`IFSB_EXT_IRQ_B_PENDING]      = extIrqBEvt;
    assign setOne[`IFSB_TIMER_FIVE_PENDING]     = timerFiveEvt;
    assign setOne[`IFSB_TIMER_FOUR_PENDING]     = timerFourEvt;
    assign setOne[`IFSB_COMPARE_OUT_FOUR_PEND]  = compareOutFourEvt;
    assign setOne[`IFSB_COMPARE_OUT_THREE_PEND] = compareOutThreeEvt;
    assign setOne[`IFSB_DMA_CHAN_TWO_DONE]      = dmaChanTwoEvt;
    assign setOne[`IFSB_CAPTURE_EIGHT_PENDING]  = captureEightEvt;
    assign setOne[`IFSB_CAPTURE_SEVEN_PENDING]  = captureSevenEvt;
    assign setOne[`IFSB_ADC_B_DONE_PENDING]     = adcBDoneEvt;
    assign setOne[`IFSB_EXT_IRQ_A_PENDING]      = extIrqAEvt;
    assign setOne[`IFSB_PIN_CHANGE_PENDING]     = pinChangeEvt;
    assign setOne[`IFSB_RSVD_ONE]               = 1'b0;
    assign setOne[`IFSB_I2C_A_MASTER_PENDING]   = i2cAMasterEvt;
    assign setOne[`IFSB_I2C_A_SLAVE_PENDING]    = i2cASlaveEvt;

    // Event wiring, second word; reserved bit has no source
    assign setTwo[`IFSB_TIMER_SIX_PENDING]      = timerSixEvt;
    assign setTwo[`IFSB_DMA_CHAN_FOUR_DONE]     = dmaChanFourEvt;
    assign setTwo[`IFSB_RSVD_TWO]               = 1'b0;
    assign setTwo[`IFSB_COMPARE_OUT_EIGHT_PEND] = compareOutEightEvt;
    assign setTwo[`IFSB_COMPARE_OUT_SEVEN_PEND] = compareOutSevenEvt;
    assign setTwo[`IFSB_COMPARE_OUT_SIX_PEND]   = compareOutSixEvt;
    assign setTwo[`IFSB_COMPARE_OUT_FIVE_PEND]  = compareOutFiveEvt;
    assign setTwo[`IFSB_CAPTURE_SIX_PENDING]    = captureSixEvt;
    assign setTwo[`IFSB_CAPTURE_FIVE_PENDING]   = captureFiveEvt;
    assign setTwo[`IFSB_CAPTURE_FOUR_PENDING]   = captureFourEvt;
    assign setTwo[`IFSB_CAPTURE_THREE_PENDING]  = captureThreeEvt;
    assign setTwo[`IFSB_DMA_CHAN_THREE_DONE]    = dmaChanThreeEvt;
    assign setTwo[`IFSB_CAN_A_EVENT_PENDING]    = canAEventEvt;
    assign setTwo[`IFSB_CAN_A_RX_READY_PENDING] = canARxReadyEvt;
    assign setTwo[`IFSB_SPI_B_EVENT_PENDING]    = spiBEventEvt;
    assign setTwo[`IFSB_SPI_B_ERROR_PENDING]    = spiBErrorEvt;

    // Bus phase tracking with a single wait state per transfer
    ifsb_ahb_port u_port (
        .core_clk    (core_clk),
        .rst         (rst),
        .hsel        (hsel),
        .haddr       (haddr),
        .htrans      (htrans),
        .hwrite      (hwrite),
        .hready      (hready),
        .hreadyout_q (hreadyout_q),
        .addr_q      (addr_q),
        .wrStb       (wrStb),
        .rdStb       (rdStb)
    );

    // Address decode; hsize is not checked, only whole words are expected
    assign hitOne = hitReg(addr_q, `IFSB_OFS_FLAGS_ONE);
    assign hitTwo = hitReg(addr_q, `IFSB_OFS_FLAGS_TWO);
    assign wrOne  = wrStb & hitOne;
    assign wrTwo  = wrStb & hitTwo;

    // Flag words; enables live elsewhere so setting never depends on them
    ifsb_flag_word #(
        .IMPL_MASK (`IFSB_IMPL_ONE)
    ) u_word_one (
        .core_clk (core_clk),
        .rst      (rst),
        .setEvt   (setOne),
        .wrEn     (wrOne),
        .wrData   (hwdata[15:0]),
        .flags_q  (flagsOne)
    );

    ifsb_flag_word #(
        .IMPL_MASK (`IFSB_IMPL_TWO)
    ) u_word_two (
        .core_clk (core_clk),
        .rst      (rst),
        .setEvt   (setTwo),
        .wrEn     (wrTwo),
        .wrData   (hwdata[15:0]),
        .flags_q  (flagsTwo)
    );

    // Read select; unmapped offsets and upper half read as zero
    assign rdMux = hitOne ? {16'h0000, flagsOne} :
                   hitTwo ? {16'h0000, flagsTwo} : 32'h0000_0000;

    // Read data registered at the end of the wait state
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            hrdata_q <= 32'h0000_0000;
            hresp_q  <= 1'b0;
        end
        else
        begin
            hresp_q <= 1'b0;
            if (rdStb)
                hrdata_q <= rdMux;
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp     = hresp_q;
    assign hrdata    = hrdata_q;

    // Checks on the sticky flags and the bus answer

    sequence s_accept;
        hsel && htrans[1] && hready;
    endsequence

    sequence s_wait_then_ready;
        !hreadyout ##1 hreadyout;
    endsequence

    property p_read_returns(logic hitSel, logic [15:0] word);
        @(posedge core_clk) disable iff (rst)
        (rdStb && hitSel) |=> (hrdata == {16'h0000, $past(word)});
    endproperty

    a_read_word_one: assert property (p_read_returns(hitOne, flagsOne))
        else $error("Read of first flag word returned wrong data");

    a_read_word_two: assert property (p_read_returns(hitTwo, flagsTwo))
        else $error("Read of second flag word returned wrong data");

    a_bus_wait_once: assert property (@(posedge core_clk) disable iff (rst)
        s_accept |=> s_wait_then_ready)
        else $error("Transfer did not answer after exactly one wait state");

    a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
        !flagsOne[`IFSB_RSVD_ONE] && !flagsTwo[`IFSB_RSVD_TWO])
        else $error("Unimplemented flag bit read as one");

    a_reserved_nowrite: assert property (@(posedge core_clk) disable iff (rst)
        (wrOne && hwdata[`IFSB_RSVD_ONE]) |=> !flagsOne[`IFSB_RSVD_ONE])
        else $error("Write reached an unimplemented bit");

    a_uart_tx_write: assert property (@(posedge core_clk) disable iff (rst)
        wrOne |=> flagsOne[`IFSB_UART_B_TX_PENDING]
                  == ($past(hwdata[`IFSB_UART_B_TX_PENDING]) | $past(uartBTxEvt)))
        else $error("Transmit flag did not follow software write");

    // A clearing write right after the request may drop the flag again
    a_uart_rx_set: assert property (@(posedge core_clk) disable iff (rst)
        uartBRxEvt |=> flagsOne[`IFSB_UART_B_RX_PENDING]
                       ##1 (flagsOne[`IFSB_UART_B_RX_PENDING] || $past(wrOne)))
        else $error("Receive flag did not set and hold");

    a_ext_irq_set: assert property (@(posedge core_clk) disable iff (rst)
        (extIrqBEvt || extIrqAEvt) |=>
        (!$past(extIrqBEvt) || flagsOne[`IFSB_EXT_IRQ_B_PENDING]) &&
        (!$past(extIrqAEvt) || flagsOne[`IFSB_EXT_IRQ_A_PENDING]))
        else $error("External input flag missed its request");

    a_timer_set: assert property (@(posedge core_clk) disable iff (rst)
        timerFiveEvt |=> flagsOne[`IFSB_TIMER_FIVE_PENDING])
        else $error("Timer five flag missed its request");

    a_timer_four_set: assert property (@(posedge core_clk) disable iff (rst)
        $rose(flagsOne[`IFSB_TIMER_FOUR_PENDING]) |-> $past(timerFourEvt) || $past(wrOne))
        else $error("Timer four flag rose without cause");

    a_timer_four_latch: assert property (@(posedge core_clk) disable iff (rst)
        timerFourEvt |=> flagsOne[`IFSB_TIMER_FOUR_PENDING])
        else $error("Timer four flag missed its request");

    a_compare_set: assert property (@(posedge core_clk) disable iff (rst)
        (compareOutFourEvt || compareOutThreeEvt) |=>
        (!$past(compareOutFourEvt) || flagsOne[`IFSB_COMPARE_OUT_FOUR_PEND]) &&
        (!$past(compareOutThreeEvt) || flagsOne[`IFSB_COMPARE_OUT_THREE_PEND]))
        else $error("Compare flag missed its request");

    a_dma_two_set: assert property (@(posedge core_clk) disable iff (rst)
        dmaChanTwoEvt |=> flagsOne[`IFSB_DMA_CHAN_TWO_DONE])
        else $error("DMA two done flag missed");

    a_capture_hi_set: assert property (@(posedge core_clk) disable iff (rst)
        (captureEightEvt || captureSevenEvt) |=>
        (!$past(captureEightEvt) || flagsOne[`IFSB_CAPTURE_EIGHT_PENDING]) &&
        (!$past(captureSevenEvt) || flagsOne[`IFSB_CAPTURE_SEVEN_PENDING]))
        else $error("Capture flags missed their requests");

    a_adc_set: assert property (@(posedge core_clk) disable iff (rst)
        adcBDoneEvt |=> flagsOne[`IFSB_ADC_B_DONE_PENDING])
        else $error("Converter done flag missed");

    a_pin_change_set: assert property (@(posedge core_clk) disable iff (rst)
        pinChangeEvt |=> flagsOne[`IFSB_PIN_CHANGE_PENDING])
        else $error("Pin change flag missed");

    a_i2c_set: assert property (@(posedge core_clk) disable iff (rst)
        i2cAMasterEvt || i2cASlaveEvt |=>
        flagsOne[1:0] == (flagsOne[1:0] | {$past(i2cAMasterEvt), $past(i2cASlaveEvt)}))
        else $error("I2C flag missed its request");

    a_word_two_high: assert property (@(posedge core_clk) disable iff (rst)
        timerSixEvt || dmaChanFourEvt |=>
        (flagsTwo[15:14] & {$past(timerSixEvt), $past(dmaChanFourEvt)})
        == {$past(timerSixEvt), $past(dmaChanFourEvt)})
        else $error("Timer six or DMA four flag missed");

    a_compare_hi_set: assert property (@(posedge core_clk) disable iff (rst)
        compareOutEightEvt |=> flagsTwo[`IFSB_COMPARE_OUT_EIGHT_PEND])
        else $error("Compare eight flag missed");

    a_compare_lo_set: assert property (@(posedge core_clk) disable iff (rst)
        (compareOutSevenEvt || compareOutSixEvt || compareOutFiveEvt) |=>
        (flagsTwo[11:9] & {$past(compareOutSevenEvt), $past(compareOutSixEvt),
                           $past(compareOutFiveEvt)})
        == {$past(compareOutSevenEvt), $past(compareOutSixEvt), $past(compareOutFiveEvt)})
        else $error("Compare five to seven flag missed");

    a_capture_lo_set: assert property (@(posedge core_clk) disable iff (rst)
        captureThreeEvt |=> flagsTwo[`IFSB_CAPTURE_THREE_PENDING])
        else $error("Capture three flag missed");

    a_capture_mid_set: assert property (@(posedge core_clk) disable iff (rst)
        (captureSixEvt || captureFiveEvt || captureFourEvt) |=>
        (flagsTwo[8:6] & {$past(captureSixEvt), $past(captureFiveEvt),
                          $past(captureFourEvt)})
        == {$past(captureSixEvt), $past(captureFiveEvt), $past(captureFourEvt)})
        else $error("Capture four to six flag missed");

    a_dma_three_set: assert property (@(posedge core_clk) disable iff (rst)
        dmaChanThreeEvt |=> flagsTwo[`IFSB_DMA_CHAN_THREE_DONE])
        else $error("DMA three done flag missed");

    a_can_event_set: assert property (@(posedge core_clk) disable iff (rst)
        canAEventEvt |=> flagsTwo[`IFSB_CAN_A_EVENT_PENDING])
        else $error("CAN event flag missed");

    a_spi_can_set: assert property (@(posedge core_clk) disable iff (rst)
        (canARxReadyEvt || spiBEventEvt || spiBErrorEvt) |=>
        (flagsTwo[2:0] & {$past(canARxReadyEvt), $past(spiBEventEvt), $past(spiBErrorEvt)})
        == {$past(canARxReadyEvt), $past(spiBEventEvt), $past(spiBErrorEvt)})
        else $error("Receive or SPI flag missed");

    a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst)
        (!wrOne && !wrTwo) |=> ((flagsOne & $past(flagsOne)) == $past(flagsOne)) &&
                               ((flagsTwo & $past(flagsTwo)) == $past(flagsTwo)))
        else $error("Flag cleared without a software write");

    a_clear_by_zero: assert property (@(posedge core_clk) disable iff (rst)
        (wrTwo && hwdata[15:0] == 16'h0000 && setTwo == 16'h0000) |=>
        flagsTwo == 16'h0000)
        else $error("Writing zero did not clear the second word");

    // Written word plus same-cycle events, implemented bits only
    a_write_one_lands: assert property (@(posedge core_clk) disable iff (rst)
        wrOne |=> flagsOne == (($past(hwdata[15:0]) | $past(setOne)) & `IFSB_IMPL_ONE))
        else $error("Write to first flag word did not land");

    a_write_two_lands: assert property (@(posedge core_clk) disable iff (rst)
        wrTwo |=> flagsTwo == (($past(hwdata[15:0]) | $past(setTwo)) & `IFSB_IMPL_TWO))
        else $error("Write to second flag word did not land");

    // Nothing pending and nothing requested keeps a word at zero
    a_idle_one_zero: assert property (@(posedge core_clk) disable iff (rst)
        (flagsOne == 16'h0000 && setOne == 16'h0000 && !wrOne) |=> flagsOne == 16'h0000)
        else $error("First flag word set with no request");

    a_idle_two_zero: assert property (@(posedge core_clk) disable iff (rst)
        (flagsTwo == 16'h0000 && setTwo == 16'h0000 && !wrTwo) |=> flagsTwo == 16'h0000)
        else $error("Second flag word set with no request");

endmodule : ifsb_flag_bank

// file: test/tb_ifsb_flag_bank.sv
// Self-checking bench for the interrupt flag status bank
`timescale 1ns/100ps
`include "ifsb_regs.svh"

module tb_ifsb_flag_bank;
    logic        core_clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic [15:0] evOne;
    logic [15:0] evTwo;
    logic [15:0] flagsOne;
    logic [15:0] flagsTwo;
    logic [31:0] rdWord;
    int          mismatches;
    int          samples_checked;

    // Single slave, so its ready is the bus ready
    ifsb_flag_bank u_dut (
        .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .uartBTxEvt(evOne[15]), .uartBRxEvt(evOne[14]), .extIrqBEvt(evOne[13]),
        .timerFiveEvt(evOne[12]), .timerFourEvt(evOne[11]), .compareOutFourEvt(evOne[10]),
        .compareOutThreeEvt(evOne[9]), .dmaChanTwoEvt(evOne[8]), .captureEightEvt(evOne[7]),
        .captureSevenEvt(evOne[6]), .adcBDoneEvt(evOne[5]), .extIrqAEvt(evOne[4]),
        .pinChangeEvt(evOne[3]), .i2cAMasterEvt(evOne[1]), .i2cASlaveEvt(evOne[0]),
        .timerSixEvt(evTwo[15]), .dmaChanFourEvt(evTwo[14]), .compareOutEightEvt(evTwo[12]),
        .compareOutSevenEvt(evTwo[11]), .compareOutSixEvt(evTwo[10]),
        .compareOutFiveEvt(evTwo[9]), .captureSixEvt(evTwo[8]), .captureFiveEvt(evTwo[7]),
        .captureFourEvt(evTwo[6]), .captureThreeEvt(evTwo[5]), .dmaChanThreeEvt(evTwo[4]),
        .canAEventEvt(evTwo[3]), .canARxReadyEvt(evTwo[2]), .spiBEventEvt(evTwo[1]),
        .spiBErrorEvt(evTwo[0]), .flagsOne(flagsOne), .flagsTwo(flagsTwo)
    );

    // 40 MHz core clock
    initial
    begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    task automatic conclude;
        if (mismatches == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        samples_checked++;
        if (seen !== expv)
        begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask : chk

    // Bounded wait for hready; a hang ends the run as a failure
    task automatic waitReady(input logic dropEv);
        int n;
        n = 0;
        do
        begin
            @(posedge core_clk);
            if (dropEv)
            begin
                evOne <= 16'h0;
                evTwo <= 16'h0;
            end
            n++;
        end
        while (hreadyout !== 1'h1 && n < 40);
        if (n >= 40)
        begin
            mismatches++;
            conclude();
        end
    endtask : waitReady

    // One single transfer; events stand only for the edge at which the write lands
    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] wd,
                        input logic [15:0] e1, input logic [15:0] e2);
        @(posedge core_clk);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        waitReady(1'h0);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wd;
        evOne <= e1;
        evTwo <= e2;
        waitReady(1'h1);
        rdWord = hrdata;
    endtask : xfer

    // One-cycle request pulse, then a few idle cycles to show it sticks
    task automatic pulse(input logic [15:0] e1, input logic [15:0] e2);
        @(posedge core_clk);
        evOne <= e1;
        evTwo <= e2;
        @(posedge core_clk);
        evOne <= 16'h0;
        evTwo <= 16'h0;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    task automatic testReset;
        chk({flagsTwo, flagsOne}, 32'h0);
        xfer(`IFSB_OFS_FLAGS_TWO, 1'h0, 32'h0, 16'h0, 16'h0);
        chk({31'h0, hresp}, 32'h0);
        chk(rdWord, 32'h0);
    endtask : testReset

    // Each bit position alone, pulsed in both words at once; flags cleared before every pulse
    task automatic testSources;
        logic [15:0] b;
        for (int i = 0; i < 16; i++)
        begin
            b = 16'h1 << i;
            xfer(`IFSB_OFS_FLAGS_ONE, 1'h1, 32'h0, 16'h0, 16'h0);
            xfer(`IFSB_OFS_FLAGS_TWO, 1'h1, 32'h0, 16'h0, 16'h0);
            pulse(b, b);
            chk({16'h0, flagsOne}, {16'h0, b & `IFSB_IMPL_ONE});
            chk({16'h0, flagsTwo}, {16'h0, b & `IFSB_IMPL_TWO});
            xfer(`IFSB_OFS_FLAGS_TWO, 1'h0, 32'h0, 16'h0, 16'h0);
            chk(rdWord, {16'h0, b & `IFSB_IMPL_TWO});
        end
    endtask : testSources

    // Software sets and clears, reserved bits, unmapped place
    task automatic testSoftware;
        xfer(`IFSB_OFS_FLAGS_ONE, 1'h1, 32'hFFFF_FFFF, 16'h0, 16'h0);
        xfer(`IFSB_OFS_FLAGS_TWO, 1'h1, 32'hFFFF_FFFF, 16'h0, 16'h0);
        xfer(`IFSB_OFS_FLAGS_ONE, 1'h0, 32'h0, 16'h0, 16'h0);
        chk(rdWord, 32'h0000_FFFB);
        xfer(`IFSB_OFS_FLAGS_TWO, 1'h0, 32'h0, 16'h0, 16'h0);
        chk(rdWord, 32'h0000_DFFF);
        xfer(`IFSB_OFS_FLAGS_ONE, 1'h1, 32'h0, 16'h0, 16'h0);
        xfer(`IFSB_OFS_FLAGS_TWO, 1'h1, 32'h0, 16'h0, 16'h0);
        xfer(32'h0000_0008, 1'h1, 32'hFFFF_FFFF, 16'h0, 16'h0);
        xfer(32'h0000_0008, 1'h0, 32'h0, 16'h0, 16'h0);
        chk(rdWord, 32'h0);
        chk({flagsTwo, flagsOne}, 32'h0);
    endtask : testSoftware

    // A request in the same cycle as a clearing write must survive
    task automatic testSetWins;
        xfer(`IFSB_OFS_FLAGS_ONE, 1'h1, 32'h0, 16'h8001, 16'h0011);
        chk({flagsTwo, flagsOne}, 32'h0011_8001);
        xfer(`IFSB_OFS_FLAGS_TWO, 1'h1, 32'h0, 16'h0, 16'h0);
        chk({flagsTwo, flagsOne}, 32'h0000_8001);
        rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        chk({flagsTwo, flagsOne}, 32'h0);
    endtask : testSetWins

    initial
    begin
        rst = 1'h1;
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = 3'h2;
        hwdata = 32'h0;
        evOne = 16'h0;
        evTwo = 16'h0;
        mismatches = 0;
        samples_checked = 0;
        repeat (8) @(posedge core_clk);
        rst <= 1'h0;
        testReset();
        testSources();
        testSoftware();
        testSetWins();
        conclude();
    end
endmodule : tb_ifsb_flag_bank
